// ---- dlcmd_defs.svh ----
/*
 fixed numbers of the download command parser: tag, codes, field widths,
 bus offsets, bus responses and the frequency step.
 assumes it is included by bare name from each file that needs it.
*/
`ifndef DLCMD_DEFS_SVH
`define DLCMD_DEFS_SVH

// message tag, 24 bits
`define DL_TAG           24'h9F9C05
// priority codes
`define PRI_NEXT_CYCLE   8'h00
`define PRI_NOW          8'h01
`define PRI_DEFERRED     8'h02
`define PRI_NOW_NOEXC    8'h03
// location method codes
`define LOC_CHANMAP      8'h00
`define LOC_EXPLICIT     8'h01
// modulation codes
`define MOD_MODEM        8'h00
`define MOD_QAM64        8'h01
`define MOD_QAM256       8'h02
// stream locate codes
`define SLM_PID          8'h00
`define SLM_PROGRAM      8'h01
// frequency step in kHz
`define FREQ_STEP_KHZ    32'd250
// register byte offsets
`define REG_CTRL         4'h0
`define REG_STATUS       4'h4
`define REG_LOC_A        4'h8
`define REG_LOC_B        4'hC
// axi responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
// parser field positions
`define PID_MSB          12
`define RSV_MSB          15
`define RSV_LSB          13

`endif

// ---- dlcmd_pkg.sv ----
/*
 types shared by the download command parser files.
 assumes dlcmd_defs.svh is on the include path.
*/
package dlcmd_pkg;
	// decoded command result
	typedef struct packed {
		logic [7:0]  priorityCode;
		logic [7:0]  locationMethod;
		logic [15:0] channelSourceRef;
		logic        reuseSourceRef;
		logic [15:0] freqSteps;
		logic [7:0]  modulation;
		logic [7:0]  streamLocateMethod;
		logic [12:0] pid;
		logic [15:0] programNumber;
	} dl_cmd_s;

	// incoming message byte stream
	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} byte_in_s;
endpackage

// ---- dl_field_store.sv ----
/*
 small register store holding the last accepted command; read data come
 from a register.
 assumes a single clock and an active low asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dlcmd_defs.svh"

module dl_field_store (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             wrEn,
	input  wire dlcmd_pkg::dl_cmd_s wrCmd,
	input  wire logic [3:0]       rdAddr,
	output logic      [31:0]      rdData
);
	import dlcmd_pkg::*;

	dl_cmd_s    held;      // stored command
	dl_cmd_s    next_held;
	logic [31:0] next_rdData;

	// load on accept, mux read word
	always_comb begin
		next_held = wrEn ? wrCmd : held;
		case (rdAddr)
			`REG_LOC_A: next_rdData = {held.freqSteps, held.channelSourceRef};
			`REG_LOC_B: next_rdData = {held.streamLocateMethod, held.modulation,
				(held.streamLocateMethod == `SLM_PID) ? {3'b000, held.pid} : held.programNumber};
			default:    next_rdData = {held.priorityCode, held.locationMethod,
				15'h0000, held.reuseSourceRef};
		endcase
	end

	// register stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held   <= '0;
			rdData <= 32'h00000000;
		end else begin
			held   <= next_held;
			rdData <= next_rdData;
		end
	end
endmodule
`default_nettype wire

// ---- dl_command_parser.sv ----
/*
 download command parser: takes the command message byte stream from the
 card, checks tag and codes, and publishes the location and priority.
 assumes the byte stream comes from same-clock logic, length field
 already stripped, one byte per valid cycle, last on the final byte.
*/
// The implementer's own choices: the AXI4-Lite slave port and the address map.
// Function
// [R1] card sends tag to start download
// [R2] explicit location overrides channel source ref
// [R3] decode priority code, reserved above three
// [R4] method zero: sixteen-bit channel source ref
// [R5] method one: frequency, modulation, stream
// [R6] zero source ref reuses previous one
// [R7] frequency counts quarter megahertz steps
// [R8] card zeroes frequency for method 02
// [R9] decode modulation, reserved above two
// [R10] decode stream locate, reserved above one
// [R11] PID: skip three bits, thirteen bits
// [R12] program number sixteen bits
// [R13] discard commands with reserved codes
`timescale 1ns/10ps
`default_nettype none
`include "dlcmd_defs.svh"

module dl_command_parser (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire dlcmd_pkg::byte_in_s msgIn,
	// axi4-lite slave
	input  wire logic [3:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [3:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// decoded results
	output logic                     downloadNow,
	output logic                     cmdValid,
	output logic [31:0]              freqKhz
);
	import dlcmd_pkg::*;

	typedef enum {
		S_TAG, S_PRI, S_LOC, S_SRC, S_FREQ, S_MOD, S_SLM, S_ID, S_DONE, S_DROP
	} parse_e;

	parse_e      state;        // parser position
	parse_e      next_state;
	logic [1:0]  cnt;          // byte count within field
	logic [1:0]  next_cnt;
	logic [23:0] sh;           // field shift register
	logic [23:0] next_sh;
	dl_cmd_s     cmd;          // command being built
	dl_cmd_s     next_cmd;
	logic [15:0] prevSrc;      // last nonzero source ref
	logic [15:0] next_prevSrc;
	logic        accept;       // pulse: good command complete
	logic        enable;       // control bit: parser on
	logic        next_enable;
	logic        acceptSticky; // status: a command arrived
	logic        next_acceptSticky;
	logic        dropSticky;   // status: a command discarded
	logic        next_dropSticky;
	logic        dropPulse;
	logic [7:0]  acceptCount;
	logic [7:0]  next_acceptCount;
	logic [31:0] storeRd;
	logic        next_downloadNow;
	logic        next_cmdValid;
	logic [31:0] next_freqKhz;

	// reserved-range checks, used in several branches
	function automatic logic codeOk(input logic [7:0] c, input logic [7:0] maxc);
		codeOk = (c <= maxc);
	endfunction

	// byte parser
	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_sh      = sh;
		next_cmd     = cmd;
		next_prevSrc = prevSrc;
		accept       = 1'b0;
		dropPulse    = 1'b0;
		if (msgIn.valid && enable) begin
			next_sh  = {sh[15:0], msgIn.data};
			next_cnt = cnt + 2'd1;
			case (state)
				S_TAG: begin
					// [R1] tag check
					if (cnt == 2'd2) begin
						next_cnt   = 2'd0;
						next_state = ({sh[15:0], msgIn.data} == `DL_TAG) ? S_PRI : S_DROP;
					end
				end
				S_PRI: begin
					// [R3] priority decode
					next_cmd.priorityCode = msgIn.data;
					next_cnt   = 2'd0;
					next_state = codeOk(msgIn.data, `PRI_NOW_NOEXC) ? S_LOC : S_DROP;
				end
				S_LOC: begin
					// [R4] [R5] location method select
					next_cmd.locationMethod = msgIn.data;
					next_cnt = 2'd0;
					if (msgIn.data == `LOC_CHANMAP)
						next_state = S_SRC;
					else if (msgIn.data == `LOC_EXPLICIT)
						next_state = S_FREQ;
					else
						next_state = S_DROP;
				end
				S_SRC: begin
					if (cnt == 2'd1) begin
						next_cnt = 2'd0;
						next_state = S_DONE;
						// [R6] zero reuses previous reference
						if ({sh[7:0], msgIn.data} == 16'h0000) begin
							next_cmd.channelSourceRef = prevSrc;
							next_cmd.reuseSourceRef   = 1'b1;
						end else begin
							next_cmd.channelSourceRef = {sh[7:0], msgIn.data};
							next_cmd.reuseSourceRef   = 1'b0;
						end
					end
				end
				S_FREQ: begin
					// [R7] quarter megahertz step count
					if (cnt == 2'd1) begin
						next_cnt = 2'd0;
						next_cmd.freqSteps = {sh[7:0], msgIn.data};
						next_state = S_MOD;
					end
				end
				S_MOD: begin
					// [R9] modulation decode
					next_cmd.modulation = msgIn.data;
					next_cnt   = 2'd0;
					next_state = codeOk(msgIn.data, `MOD_QAM256) ? S_SLM : S_DROP;
				end
				S_SLM: begin
					// [R10] stream locate decode
					next_cmd.streamLocateMethod = msgIn.data;
					next_cnt   = 2'd0;
					next_state = codeOk(msgIn.data, `SLM_PROGRAM) ? S_ID : S_DROP;
				end
				S_ID: begin
					if (cnt == 2'd1) begin
						next_cnt   = 2'd0;
						next_state = S_DONE;
						if (cmd.streamLocateMethod == `SLM_PID)
							// [R11] skip three, take pid
							next_cmd.pid = {sh[4:0], msgIn.data};
						else
							// [R12] program number
							next_cmd.programNumber = {sh[7:0], msgIn.data};
					end
				end
				S_DONE: begin
					// bytes past the defined end are ignored
					next_cnt = 2'd0;
				end
				S_DROP: begin
					next_cnt = 2'd0;
				end
				default: begin
					next_state = S_DROP;
				end
			endcase
			// end of message closes the command
			if (msgIn.last) begin
				// judge the field walk before rewinding to the tag
				if (next_state == S_DONE) begin
					accept = 1'b1;
					// [R6] remember a nonzero reference
					if (next_cmd.locationMethod == `LOC_CHANMAP)
						next_prevSrc = next_cmd.channelSourceRef;
				end else begin
					// [R13] incomplete or reserved: discard
					dropPulse = 1'b1;
				end
				next_state = S_TAG;
				next_cnt   = 2'd0;
			end
		end
	end

	// parser state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= S_TAG;
			cnt     <= 2'd0;
			sh      <= 24'h000000;
			cmd     <= '0;
			prevSrc <= 16'h0000;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			sh      <= next_sh;
			cmd     <= next_cmd;
			prevSrc <= next_prevSrc;
		end
	end

	// accepted command store
	dl_field_store u_store (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (accept),
		.wrCmd  (next_cmd),
		.rdAddr (s_axi_araddr),
		.rdData (storeRd)
	);

	// axi slave: write and read handshake state
	logic       awHeld, next_awHeld;
	logic [3:0] awAddr, next_awAddr;
	logic       wHeld,  next_wHeld;
	logic [31:0] wData, next_wData;
	logic       next_bvalid;
	logic [1:0] next_bresp;
	logic       rPend, next_rPend;   // read data one cycle behind store
	logic [3:0] rAddr, next_rAddr;
	logic       next_rvalid;
	logic [1:0] next_rresp;
	logic [31:0] next_rdata;
	logic       doWrite;

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !rPend && !s_axi_rvalid;

	// register access and status
	always_comb begin
		next_awHeld = awHeld || (s_axi_awvalid && s_axi_awready);
		next_awAddr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awAddr;
		next_wHeld  = wHeld || (s_axi_wvalid && s_axi_wready);
		next_wData  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wData;
		doWrite     = next_awHeld && next_wHeld && !s_axi_bvalid;
		next_bvalid = s_axi_bvalid ? !s_axi_bready : doWrite;
		next_bresp  = s_axi_bresp;
		next_enable = enable;
		// sticky status: set wins over clear
		next_acceptSticky = acceptSticky;
		next_dropSticky   = dropSticky;
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bresp  = `RESP_OKAY;
			if (next_awAddr == `REG_CTRL) begin
				if (s_axi_wstrb[0])
					next_enable = next_wData[0];
			end else if (next_awAddr == `REG_STATUS) begin
				if (s_axi_wstrb[0] && next_wData[0])
					next_acceptSticky = 1'b0;
				if (s_axi_wstrb[0] && next_wData[1])
					next_dropSticky = 1'b0;
			end else if (next_awAddr != `REG_LOC_A && next_awAddr != `REG_LOC_B) begin
				next_bresp = `RESP_SLVERR;
			end
		end
		if (accept)
			next_acceptSticky = 1'b1;
		if (dropPulse)
			next_dropSticky = 1'b1;
		next_acceptCount = acceptCount + {7'd0, accept};
		// read path: address taken, data two cycles later
		next_rPend  = s_axi_arvalid && s_axi_arready;
		next_rAddr  = next_rPend ? s_axi_araddr : rAddr;
		next_rvalid = s_axi_rvalid ? !s_axi_rready : rPend;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (rPend) begin
			next_rresp = `RESP_OKAY;
			case (rAddr)
				`REG_CTRL:   next_rdata = {31'h00000000, enable};
				`REG_STATUS: next_rdata = {acceptCount, 22'h000000, dropSticky, acceptSticky};
				`REG_LOC_A:  next_rdata = storeRd;
				`REG_LOC_B:  next_rdata = storeRd;
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = `RESP_SLVERR;
				end
			endcase
		end
		// published results
		next_cmdValid    = cmdValid || accept;
		next_downloadNow = accept ? (next_cmd.priorityCode == `PRI_NOW ||
			next_cmd.priorityCode == `PRI_NOW_NOEXC) : 1'b0;
		// [R7] [R2] explicit frequency in kHz
		next_freqKhz = accept ? 32'(next_cmd.freqSteps * `FREQ_STEP_KHZ) : freqKhz;
	end

	// bus and status registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0; awAddr <= 4'h0; wHeld <= 1'b0; wData <= 32'h00000000;
			s_axi_bvalid <= 1'b0; s_axi_bresp <= `RESP_OKAY;
			rPend <= 1'b0; rAddr <= 4'h0;
			s_axi_rvalid <= 1'b0; s_axi_rresp <= `RESP_OKAY; s_axi_rdata <= 32'h00000000;
			enable <= 1'b1; acceptSticky <= 1'b0; dropSticky <= 1'b0;
			acceptCount <= 8'h00; cmdValid <= 1'b0; downloadNow <= 1'b0;
			freqKhz <= 32'h00000000;
		end else begin
			awHeld <= next_awHeld; awAddr <= next_awAddr;
			wHeld <= next_wHeld; wData <= next_wData;
			s_axi_bvalid <= next_bvalid; s_axi_bresp <= next_bresp;
			rPend <= next_rPend; rAddr <= next_rAddr;
			s_axi_rvalid <= next_rvalid; s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
			enable <= next_enable; acceptSticky <= next_acceptSticky;
			dropSticky <= next_dropSticky; acceptCount <= next_acceptCount;
			cmdValid <= next_cmdValid; downloadNow <= next_downloadNow;
			freqKhz <= next_freqKhz;
		end
	end
endmodule
`default_nettype wire

// ---- dl_parser_chk.sv ----
/*
 port checker for the download command parser.
 assumes one clock, reset low, bound onto dl_command_parser.
*/
`timescale 1ns/10ps
`default_nettype none
module dl_parser_chk (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire dlcmd_pkg::byte_in_s msgIn,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic                downloadNow,
	input wire logic                cmdValid,
	input wire logic [31:0]         freqKhz
);
	import dlcmd_pkg::*;
	logic lastIn; // final byte of a message taken
	assign lastIn = msgIn.valid && msgIn.last;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// read address handshake
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// both write channels taken together
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	chk_now_pulse: assert property (
		downloadNow |=> !downloadNow) else $error("download pulse too long");
	chk_now_cause: assert property (
		downloadNow |-> $past(lastIn) || $past(lastIn, 2)) else $error("pulse without message");
	chk_now_valid: assert property (
		downloadNow |-> cmdValid) else $error("pulse without valid command");
	chk_freq_cause: assert property (
		$changed(freqKhz) |-> $past(lastIn) || $past(lastIn, 2)) else $error("freq moved");
	chk_freq_step: assert property (
		freqKhz % 32'd250 == 32'd0) else $error("freq not in quarter steps");
	chk_read_lat: assert property (
		rdTaken |-> ##2 s_axi_rvalid) else $error("read answer late");
	chk_write_resp: assert property (
		wrTaken |=> s_axi_bvalid) else $error("write answer late");
	chk_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
endmodule
bind dl_command_parser dl_parser_chk dl_parser_chk_inst (.clk, .rst_n, .msgIn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .downloadNow, .cmdValid, .freqKhz);
`default_nettype wire

// ---- dl_card_model.sv ----
/*
 card side model: sends command messages byte by byte.
 assumes the bench calls send just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module dl_card_model (
	input  wire logic           clk,
	output dlcmd_pkg::byte_in_s msgIn
);
	import dlcmd_pkg::*;
	logic busy = 1'b0; // frame under way
	initial msgIn = '0;
	// idle data toggles so a stale byte never looks fresh
	always @(posedge clk) begin
		if (!busy) msgIn.data <= ~msgIn.data;
	end
	// tag first, then fields msb first
	task automatic send(input logic [87:0] m, input int n, input int gap);
		busy = 1'b1;
		for (int i = 0; i < n; i++) begin
			msgIn <= '{1'b1, i == n - 1, m[87 - 8 * i -: 8]};
			@(posedge clk);
			if (gap > 0) begin
				msgIn.valid <= 1'b0;
				repeat (gap) @(posedge clk);
			end
		end
		msgIn.valid <= 1'b0;
		busy = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- dl_command_parser_tb.sv ----
/*
 self-checking bench for the download command parser.
 assumes the card model and checker files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dlcmd_defs.svh"
module dl_command_parser_tb;
	import dlcmd_pkg::*;
	logic clk, rst_n, awValid, wValid, bReady, arValid, rReady;
	logic awReady, wReady, bValid, arReady, rValid, downloadNow, cmdValid;
	logic [3:0] awAddr, arAddr;
	logic [31:0] wData, rData, freqKhz;
	logic [1:0] bResp, rResp;
	byte_in_s msgIn;
	logic [32:0] nowQ[$]; // pulse notes, bit 32 skips freq
	logic [65:0] rdQ[$];  // read notes: mask, data, resp
	logic [1:0] bQ[$];    // write response notes
	logic [65:0] rq;
	logic [32:0] nq;
	logic [15:0] f, id;
	logic [7:0] md, s, p, cnt;
	int n_mismatch = 0, compares = 0, seed = 23655;
	dl_command_parser dl_command_parser_inst (.clk(clk), .rst_n(rst_n), .msgIn(msgIn),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .downloadNow(downloadNow),
		.cmdValid(cmdValid), .freqKhz(freqKhz));
	dl_card_model dl_card_model_inst (.clk(clk), .msgIn(msgIn));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// compare and count
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// one write, held until each channel is taken
	task automatic axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		bQ.push_back(er);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = awReady;
			tw = wReady;
			tb = bValid;
			@(posedge clk);
			if (ta) awValid <= 1'b0;
			if (tw) wValid <= 1'b0;
		end
		bReady <= 1'b0;
		// let an edge pass before the next request
		@(posedge clk);
	endtask
	// one read with masked expectation
	task automatic axiRd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		logic ta, tr;
		rdQ.push_back({m, e, er});
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = arReady;
			tr = rValid;
			@(posedge clk);
			if (ta) arValid <= 1'b0;
		end
		rReady <= 1'b0;
		// let an edge pass before the next request
		@(posedge clk);
	endtask
	// message, then settle time for the result
	task automatic cmd(input logic [87:0] m, input int n, input int gap);
		dl_card_model_inst.send(m, n, gap);
		repeat (3) @(posedge clk);
	endtask
	// oldest note taken whenever a result shows
	always @(negedge clk) begin
		if (downloadNow === 1'b1) begin
			if (nowQ.size() == 0) chk("unexpected pulse", 32'h1, 32'h0);
			else begin
				nq = nowQ.pop_front();
				if (!nq[32]) chk("freqKhz", freqKhz, nq[31:0]);
			end
		end
		if (rValid === 1'b1 && rReady === 1'b1) begin
			rq = rdQ.pop_front();
			chk("rdata", rData & rq[65:34], rq[33:2]);
			chk("rresp", {30'h0, rResp}, {30'h0, rq[1:0]});
		end
		if (bValid === 1'b1 && bReady === 1'b1) chk("bresp", {30'h0, bResp}, {30'h0, bQ.pop_front()});
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
	initial begin
		{rst_n, awValid, wValid, bReady, arValid, rReady} = '0;
		{awAddr, arAddr, wData} = '0;
		cnt = 8'h00;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		axiRd(`REG_CTRL, 32'h1, 32'h1, `RESP_OKAY);
		axiRd(`REG_STATUS, 32'hFFFFFFFF, 32'h0, `RESP_OKAY);
		chk("cmdValid", {31'h0, cmdValid}, 32'h0);
		for (p = 8'h00; p < 8'h04; p++) begin
			if (p[0]) nowQ.push_back({1'b1, 32'h0});
			cmd({`DL_TAG, p, `LOC_CHANMAP, 16'hA5C0 + p, 32'h0}, 7, p[1]);
			cnt++;
			axiRd(`REG_LOC_A, 32'hFFFF, {16'h0, 16'hA5C0 + p}, `RESP_OKAY);
		end
		// zero reference keeps the last one
		cmd({`DL_TAG, `PRI_DEFERRED, `LOC_CHANMAP, 48'h0}, 7, 0);
		cnt++;
		axiRd(`REG_LOC_A, 32'hFFFF, 32'hA5C3, `RESP_OKAY);
		for (md = 8'h00; md < 8'h03; md++) begin
			for (s = 8'h00; s < 8'h02; s++) begin
				f = 16'($random(seed));
				id = 16'($random(seed));
				nowQ.push_back({1'b0, 32'(f) * `FREQ_STEP_KHZ});
				cmd({`DL_TAG, `PRI_NOW, `LOC_EXPLICIT, f, md, s, id}, 11, $random(seed) & 1);
				cnt++;
				axiRd(`REG_LOC_A, 32'hFFFF0000, {f, 16'h0}, `RESP_OKAY);
				axiRd(`REG_LOC_B, 32'hFFFFFFFF, {s, md, s[0] ? id : {3'b0, id[12:0]}}, `RESP_OKAY);
			end
		end
		nowQ.push_back({1'b0, 32'h0});
		cmd({`DL_TAG, `PRI_NOW, `LOC_EXPLICIT, 16'h0000, `MOD_QAM256, `SLM_PROGRAM, 16'h0042}, 11, 0);
		cnt++;
		axiRd(`REG_LOC_A, 32'hFFFF0000, 32'h0, `RESP_OKAY);
		// reserved codes, wrong tag, short message
		cmd({`DL_TAG, 8'h04, `LOC_CHANMAP, 48'h1111_0000_0000}, 7, 0);
		cmd({`DL_TAG, `PRI_NOW, 8'h02, 48'h1111_0000_0000}, 7, 0);
		cmd({`DL_TAG, `PRI_NOW, `LOC_EXPLICIT, 16'h0010, 8'h03, `SLM_PID, 16'h0020}, 11, 0);
		cmd({`DL_TAG, `PRI_NOW, `LOC_EXPLICIT, 16'h0010, `MOD_QAM64, 8'h02, 16'h0020}, 11, 0);
		cmd({24'h9F9C04, `PRI_NOW, `LOC_CHANMAP, 48'h1111_0000_0000}, 7, 0);
		cmd({`DL_TAG, `PRI_NOW, `LOC_EXPLICIT, 16'h0010, `MOD_QAM64, `SLM_PID, 16'h0020}, 8, 0);
		axiRd(`REG_STATUS, 32'hFF000003, {cnt, 24'h3}, `RESP_OKAY);
		axiWr(`REG_STATUS, 32'h2, `RESP_OKAY);
		axiRd(`REG_STATUS, 32'h3, 32'h1, `RESP_OKAY);
		// parsing switched off, then back on
		axiWr(`REG_CTRL, 32'h0, `RESP_OKAY);
		cmd({`DL_TAG, `PRI_NOW, `LOC_CHANMAP, 48'h2222_0000_0000}, 7, 0);
		axiWr(`REG_CTRL, 32'h1, `RESP_OKAY);
		axiRd(`REG_STATUS, 32'hFF000000, {cnt, 24'h0}, `RESP_OKAY);
		// unmapped place
		axiRd(4'h2, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
		axiWr(4'h2, 32'h5, `RESP_SLVERR);
		repeat (4) @(posedge clk);
		chk("cmdValid", {31'h0, cmdValid}, 32'h1);
		chk("notes left", nowQ.size() + rdQ.size() + bQ.size(), 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
